// *** rtl/dma_chan_pkg.sv ***
package dma_chan_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DEST_START_ADDR = 8'h00;
	localparam logic [7:0] OFS_SRC_SIZE        = 8'h04;
	localparam logic [7:0] OFS_DEST_SIZE       = 8'h08;
	localparam logic [7:0] OFS_SRC_POINTER     = 8'h0c;
	localparam logic [7:0] OFS_DEST_POINTER    = 8'h10;
	localparam logic [7:0] OFS_CONTROL         = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS      = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLEAR       = 8'h1c;
	localparam logic [7:0] OFS_IRQ_ENABLE      = 8'h20;

	// ----------------------------------------------------------------
	// widths and field positions
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int SIZE_W  = 16;
	localparam int FLAG_N  = 5;

	localparam int CTRL_PATTERN_MODE_BIT = 0;

	localparam int FLAG_SRC_DONE       = 4;
	localparam int FLAG_SRC_HALF_EMPTY = 3;
	localparam int FLAG_DEST_DONE      = 2;
	localparam int FLAG_DEST_HALF_FULL = 1;
	localparam int FLAG_BLOCK_COMPLETE = 0;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_DEST_START_ADDR = 32'h0000_0000;
	localparam logic [15:0] RST_SIZE            = 16'h0000;
	localparam logic [15:0] RST_POINTER         = 16'h0000;
	localparam logic [4:0]  RST_FLAGS           = 5'h00;
	localparam logic [31:0] RST_RDATA           = 32'h0000_0000;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	// a stored size of zero stands for this many bytes
	localparam logic [16:0] SIZE_ZERO_MEANS = 17'h1_0000;

	typedef enum logic [1:0] {
		SIDE_SRC,
		SIDE_DEST
	} side_t;

endpackage : dma_chan_pkg

// *** rtl/dma_channel_address_size_regs.sv ***
// Operation
// R1 - the destination start address is a 32-bit read/write register cleared to zero at reset.
// R2 - software must load the start address with a physical bus address, used untranslated.
// R3 - the source size counts bytes, with zero meaning 65,536 bytes.
// R4 - the destination size counts bytes, with zero meaning 65,536 bytes.
// R5 - bits 31 to 16 of both size registers and the source pointer read as zero and ignore writes.
// R6 - the source pointer is a read-only 16-bit index of the current source byte, zero after reset.
// R7 - in pattern-detect mode a pattern match clears the source pointer to zero.
// R8 - source done is raised when the pointer reaches the source size, source half empty at half of it.
// R9 - destination done is raised when its pointer reaches the destination size, half full at half of it.
// R10 - block complete is raised once the larger of the two sizes has moved, or on a pattern match; the code raises it on a match only in pattern-detect mode.
// R11 - the source pointer steps by one per source byte and wraps to zero after the last byte.
//
// The placing of the registers and the plain strobed port were decided locally.
module dma_channel_address_size_regs (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	// byte mover events
	input  wire logic        src_byte_moved,
	input  wire logic        dest_byte_moved,
	input  wire logic        pattern_match,
	// channel configuration to the byte mover
	output logic      [31:0] dest_start_addr,
	output logic      [15:0] src_byte_count,
	output logic      [15:0] dest_byte_count,
	output logic      [15:0] src_byte_index,
	output logic      [15:0] dest_byte_index,
	output logic             pattern_mode,
	// interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	function automatic logic [16:0] bytes_of(input logic [15:0] size);
		if (size == 16'h0000) begin
			bytes_of = dma_chan_pkg::SIZE_ZERO_MEANS;
		end else begin
			bytes_of = {1'b0, size};
		end
	endfunction : bytes_of

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// ----------------------------------------------------------------
	// internal state
	// ----------------------------------------------------------------
	logic [4:0]  flags;
	logic [4:0]  flag_enable;
	logic [4:0]  flag_set;
	logic [4:0]  flag_clear;
	logic [16:0] src_total;
	logic [16:0] dest_total;
	logic [16:0] src_moved_after;
	logic [16:0] dest_moved_after;
	logic        src_end;
	logic        src_half;
	logic        dest_end;
	logic        dest_half;
	logic        match_event;
	logic        block_end;
	logic [31:0] next_rdata;

	// ----------------------------------------------------------------
	// progress comparisons
	// ----------------------------------------------------------------
	assign src_total        = bytes_of(src_byte_count);              // [R3]
	assign dest_total       = bytes_of(dest_byte_count);             // [R4]
	assign src_moved_after  = {1'b0, src_byte_index} + 17'h0_0001;
	assign dest_moved_after = {1'b0, dest_byte_index} + 17'h0_0001;
	assign match_event      = pattern_mode & pattern_match;

	// a size of one has no midpoint byte, so half never fires for it
	assign src_end   = src_byte_moved & (src_moved_after == src_total);            // [R8]
	assign src_half  = src_byte_moved & (src_moved_after == (src_total >> 1));     // [R8]
	assign dest_end  = dest_byte_moved & (dest_moved_after == dest_total);         // [R9]
	assign dest_half = dest_byte_moved & (dest_moved_after == (dest_total >> 1));  // [R9]

	// the longer side finishing ends the block; on equal sizes the source decides
	always_comb begin
		if (src_total >= dest_total) begin
			block_end = src_end;                                   // [R10]
		end else begin
			block_end = dest_end;                                  // [R10]
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dest_start_addr <= dma_chan_pkg::RST_DEST_START_ADDR;  // [R1]
		end else if (reg_write && hit(reg_addr, dma_chan_pkg::OFS_DEST_START_ADDR)) begin
			dest_start_addr <= reg_wdata;                          // [R1]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			src_byte_count <= dma_chan_pkg::RST_SIZE;
		end else if (reg_write && hit(reg_addr, dma_chan_pkg::OFS_SRC_SIZE)) begin
			src_byte_count <= reg_wdata[15:0];                     // [R5]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dest_byte_count <= dma_chan_pkg::RST_SIZE;
		end else if (reg_write && hit(reg_addr, dma_chan_pkg::OFS_DEST_SIZE)) begin
			dest_byte_count <= reg_wdata[15:0];                    // [R5]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pattern_mode <= 1'b0;
		end else if (reg_write && hit(reg_addr, dma_chan_pkg::OFS_CONTROL)) begin
			pattern_mode <= reg_wdata[dma_chan_pkg::CTRL_PATTERN_MODE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flag_enable <= dma_chan_pkg::RST_FLAGS;
		end else if (reg_write && hit(reg_addr, dma_chan_pkg::OFS_IRQ_ENABLE)) begin
			flag_enable <= reg_wdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// source pointer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			src_byte_index <= dma_chan_pkg::RST_POINTER;           // [R6]
		end else if (match_event) begin
			src_byte_index <= dma_chan_pkg::RST_POINTER;           // [R7]
		end else if (src_end) begin
			src_byte_index <= dma_chan_pkg::RST_POINTER;           // [R11]
		end else if (src_byte_moved) begin
			src_byte_index <= src_byte_index + 16'h0001;           // [R11]
		end
	end

	// ----------------------------------------------------------------
	// destination pointer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dest_byte_index <= dma_chan_pkg::RST_POINTER;
		end else if (dest_end) begin
			dest_byte_index <= dma_chan_pkg::RST_POINTER;
		end else if (dest_byte_moved) begin
			dest_byte_index <= dest_byte_index + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// sticky event flags
	// ----------------------------------------------------------------
	always_comb begin
		flag_set = 5'h00;
		flag_set[dma_chan_pkg::FLAG_SRC_DONE]       = src_end;                 // [R8]
		flag_set[dma_chan_pkg::FLAG_SRC_HALF_EMPTY] = src_half;                // [R8]
		flag_set[dma_chan_pkg::FLAG_DEST_DONE]      = dest_end;                // [R9]
		flag_set[dma_chan_pkg::FLAG_DEST_HALF_FULL] = dest_half;               // [R9]
		flag_set[dma_chan_pkg::FLAG_BLOCK_COMPLETE] = block_end | match_event; // [R10]
	end

	always_comb begin
		if (reg_write && hit(reg_addr, dma_chan_pkg::OFS_IRQ_CLEAR)) begin
			flag_clear = reg_wdata[4:0];
		end else begin
			flag_clear = 5'h00;
		end
	end

	// a set in the same cycle as its clear wins
	always_ff @(posedge clk) begin
		if (rst) begin
			flags <= dma_chan_pkg::RST_FLAGS;
		end else begin
			for (int i = 0; i < dma_chan_pkg::FLAG_N; i++) begin
				flags[i] <= flag_set[i] | (flags[i] & ~flag_clear[i]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags & flag_enable);
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = dma_chan_pkg::RST_RDATA;
		if (reg_read) begin
			case (reg_addr)
				dma_chan_pkg::OFS_DEST_START_ADDR: begin
					next_rdata = dest_start_addr;                  // [R1]
				end
				dma_chan_pkg::OFS_SRC_SIZE: begin
					next_rdata = {16'h0000, src_byte_count};       // [R5]
				end
				dma_chan_pkg::OFS_DEST_SIZE: begin
					next_rdata = {16'h0000, dest_byte_count};      // [R5]
				end
				dma_chan_pkg::OFS_SRC_POINTER: begin
					next_rdata = {16'h0000, src_byte_index};       // [R5] [R6]
				end
				dma_chan_pkg::OFS_DEST_POINTER: begin
					next_rdata = {16'h0000, dest_byte_index};
				end
				dma_chan_pkg::OFS_CONTROL: begin
					next_rdata = {31'h0000_0000, pattern_mode};
				end
				dma_chan_pkg::OFS_IRQ_STATUS: begin
					next_rdata = {27'h000_0000, flags};
				end
				dma_chan_pkg::OFS_IRQ_ENABLE: begin
					next_rdata = {27'h000_0000, flag_enable};
				end
				default: begin
					next_rdata = dma_chan_pkg::RST_RDATA;
				end
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= dma_chan_pkg::RST_RDATA;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : dma_channel_address_size_regs

// *** tb/byte_mover_model.sv ***
module byte_mover_model (
	// clock, reset, job
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [16:0] src_n,
	input  wire logic [16:0] dest_n,
	input  wire logic        slow,
	// byte events
	output logic             src_byte_moved,
	output logic             dest_byte_moved,
	output logic             busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [16:0] src_left;
	logic [16:0] dest_left;
	logic        gap;
	// slow mode leaves an idle cycle between bytes
	assign src_byte_moved  = (src_left != 17'h0) && !gap;
	assign dest_byte_moved = (dest_left != 17'h0) && !gap;
	assign busy            = (src_left != 17'h0) || (dest_left != 17'h0);
	always_ff @(posedge clk) begin
		if (rst || start) begin
			src_left  <= rst ? 17'h0 : src_n;
			dest_left <= rst ? 17'h0 : dest_n;
			gap       <= 1'b0;
		end else begin
			gap       <= slow && !gap;
			src_left  <= src_left - {16'h0, src_byte_moved};
			dest_left <= dest_left - {16'h0, dest_byte_moved};
		end
	end
endmodule : byte_mover_model

// *** tb/dma_channel_address_size_regs_tb_top.sv ***
module dma_channel_address_size_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, pattern_match = 1'b0;
	logic        start = 1'b0, slow = 1'b0, irq, busy, src_byte_moved, dest_byte_moved;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	logic [16:0] src_n = 17'h0, dest_n = 17'h0;
	int          bad_count = 0, tests_run = 0, seed = 32'h20d0, p = 0, s, k, f;

	dma_channel_address_size_regs u_dma_channel_address_size_regs (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .src_byte_moved(src_byte_moved),
		.dest_byte_moved(dest_byte_moved), .pattern_match(pattern_match), .dest_start_addr(),
		.src_byte_count(), .dest_byte_count(), .src_byte_index(), .dest_byte_index(), .pattern_mode(), .irq(irq)
	);
	byte_mover_model u_byte_mover_model (
		.clk(clk), .rst(rst), .start(start), .src_n(src_n), .dest_n(dest_n), .slow(slow),
		.src_byte_moved(src_byte_moved), .dest_byte_moved(dest_byte_moved), .busy(busy)
	);
	always #2 clk = ~clk;

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge clk);
	endtask : rc
	task automatic run(input logic [16:0] ns, input logic [16:0] nd, input logic sl);
		src_n <= ns;
		dest_n <= nd;
		slow <= sl;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 0; i <= 70000; i++) begin
			@(posedge clk);
			if (!busy) break;
			if (i == 70000) begin
				bad_count++;
				end_of_test();
			end
		end
	endtask : run
	task automatic pulse();
		pattern_match <= 1'b1;
		@(posedge clk);
		pattern_match <= 1'b0;
		@(posedge clk);
	endtask : pulse
	// walks the source pointer over k bytes, returns the flags raised
	function automatic int exp_src(input int s, input int k, inout int p);
		int r;
		r = 0;
		for (int i = 0; i < k; i++) begin
			if (p + 1 == s / 2) r |= 8;
			if (p + 1 == s) begin
				r |= 16;
				p = 0;
			end else begin
				p++;
			end
		end
		return r;
	endfunction : exp_src

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rc(8'(i * 4), 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			wr(8'h00, d); // random physical bus address
			rc(8'h00, d);
			wr(8'h04, d);
			rc(8'h04, d & 32'hffff);
			wr(8'h08, ~d);
			rc(8'h08, ~d & 32'hffff);
			wr(8'h0c, d);
			rc(8'h0c, 32'h0);
			wr(8'h40, d);
			rc(8'h40, 32'h0);
		end
		wr(8'h04, 32'h4);
		wr(8'h08, 32'h2);
		run(17'h4, 17'h2, 1'b1);
		rc(8'h18, 32'h1f);
		rc(8'h0c, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h20, 32'h1f);
		@(posedge clk);
		#1 chk({31'h0, irq}, 32'h1);
		wr(8'h1c, 32'h1f);
		@(posedge clk);
		#1 chk({31'h0, irq}, 32'h0);
		rc(8'h18, 32'h0);
		wr(8'h08, 32'hffff);
		for (int i = 0; i < 10; i++) begin
			s = 1 + $unsigned($random(seed)) % 16;
			k = 1 + $unsigned($random(seed)) % 24;
			wr(8'h04, 32'(s));
			run(17'(k), 17'h0, 1'($random(seed)));
			f = exp_src(s, k, p);
			rc(8'h0c, 32'(p));
			rc(8'h18, 32'(f));
			wr(8'h1c, 32'h1f);
		end
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h0);
		run(17'h10000, 17'h10000, 1'b0);
		f = exp_src(65536, 65536, p);
		rc(8'h0c, 32'(p));
		rc(8'h18, 32'(f) | 32'h7);
		wr(8'h1c, 32'h1f);
		run(17'h3, 17'h0, 1'b0);
		f = exp_src(65536, 3, p);
		pulse();
		rc(8'h0c, 32'(p));
		rc(8'h18, 32'(f));
		wr(8'h14, 32'h1);
		pulse();
		rc(8'h0c, 32'h0);
		rc(8'h18, 32'(f) | 32'h1);
		end_of_test();
	end
endmodule : dma_channel_address_size_regs_tb_top

// *** tb/dma_regs_checker_sva.sv ***
module dma_regs_checker (
	// clock, reset, register port
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	// byte events and channel state
	input wire logic        src_byte_moved,
	input wire logic        dest_byte_moved,
	input wire logic        pattern_match,
	input wire logic        pattern_mode,
	input wire logic [31:0] dest_start_addr,
	input wire logic [15:0] src_byte_count,
	input wire logic [15:0] dest_byte_count,
	input wire logic [15:0] src_byte_index,
	input wire logic [15:0] dest_byte_index
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic src_clr;
	logic src_last;
	logic dest_last;
	// a stored size of zero counts as 65536
	assign src_clr   = pattern_match && pattern_mode;
	assign src_last  = ({1'b0, src_byte_index} + 17'h1) == {src_byte_count == 16'h0, src_byte_count};
	assign dest_last = ({1'b0, dest_byte_index} + 17'h1) == {dest_byte_count == 16'h0, dest_byte_count};
	sequence s_src_step;
		src_byte_moved && !src_clr && !src_last;
	endsequence
	sequence s_src_wrap;
		src_byte_moved && !src_clr && src_last;
	endsequence
	a_addr_write: assert property (reg_write && reg_addr == 8'h00 |=> dest_start_addr == $past(reg_wdata))
		else $error("start address");
	a_src_size: assert property (reg_write && reg_addr == 8'h04 |=> src_byte_count == $past(reg_wdata[15:0]))
		else $error("source size");
	a_dest_size: assert property (reg_write && reg_addr == 8'h08 |=> dest_byte_count == $past(reg_wdata[15:0]))
		else $error("destination size");
	a_upper_zero: assert property (reg_read && reg_addr inside {8'h04, 8'h08, 8'h0c} |=> reg_rdata[31:16] == 16'h0)
		else $error("upper bits");
	a_ptr_read: assert property (reg_read && reg_addr == 8'h0c |=> reg_rdata == {16'h0, $past(src_byte_index)})
		else $error("pointer read");
	a_src_step: assert property (s_src_step |=> src_byte_index == $past(src_byte_index) + 16'h1)
		else $error("pointer step");
	a_src_wrap: assert property (s_src_wrap |=> src_byte_index == 16'h0)
		else $error("pointer wrap");
	a_pattern_clear: assert property (src_clr |=> src_byte_index == 16'h0)
		else $error("pattern clear");
	a_ptr_hold: assert property (!src_byte_moved && !pattern_match |=> $stable(src_byte_index))
		else $error("pointer moved");
	a_dest_wrap: assert property (dest_byte_moved && dest_last |=> dest_byte_index == 16'h0)
		else $error("dest wrap");
endmodule : dma_regs_checker

bind dma_channel_address_size_regs dma_regs_checker u_dma_regs_checker (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .src_byte_moved(src_byte_moved),
	.dest_byte_moved(dest_byte_moved), .pattern_match(pattern_match), .pattern_mode(pattern_mode),
	.dest_start_addr(dest_start_addr), .src_byte_count(src_byte_count), .dest_byte_count(dest_byte_count),
	.src_byte_index(src_byte_index), .dest_byte_index(dest_byte_index)
);
